// ### logic/dmc_cache.sv
`timescale 1ns/1ps
module dmc_cache
  import dmc_pkg::*;
#(
  parameter int LINES = NUM_LINES,
  parameter int WAYS  = NUM_WAYS,
  parameter int WORDS = LINE_WORDS
) (
  // Clock and reset
  input  wire logic                i_clk_sys,
  input  wire logic                i_reset_n,
  input  wire logic                i_clk_en,
  // Configuration
  input  wire logic                i_write_allocate,
  // Core load/store port
  input  wire logic                i_req_valid,
  input  wire logic                i_req_write,
  input  wire logic [ADDR_W-1:0]   i_req_addr,
  input  wire logic [DATA_W-1:0]   i_req_wdata,
  output logic                     o_req_ready,
  output logic                     o_rsp_valid,
  output logic [DATA_W-1:0]        o_rsp_rdata,
  // Preload hint port
  input  wire logic                i_pld_valid,
  input  wire logic [1:0]          i_pld_kind,
  input  wire logic [ADDR_W-1:0]   i_pld_addr,
  output logic                     o_pld_ready,
  // Instruction preload hint to instruction cache
  output logic                     o_instruction_preload_hint,
  output logic [ADDR_W-1:0]        o_ipre_addr,
  input  wire logic                i_ipre_ready,
  // Main memory line read
  output logic                     o_mem_rd_req,
  output logic [ADDR_W-1:0]        o_mem_rd_addr,
  input  wire logic                i_mem_rd_valid,
  input  wire logic [DATA_W-1:0]   i_mem_rd_data,
  // Main memory word write
  output logic                     o_mem_wr_req,
  output logic [ADDR_W-1:0]        o_mem_wr_addr,
  output logic [DATA_W-1:0]        o_mem_wr_data,
  input  wire logic                i_mem_wr_ack
);

  localparam int SETS   = LINES / WAYS;
  localparam int OFF_W  = $clog2(WORDS);
  localparam int IDX_W  = $clog2(SETS);
  localparam int WAY_W  = (WAYS > 1) ? $clog2(WAYS) : 1;
  localparam int LINE_W = $clog2(LINES);
  localparam int TAG_W  = ADDR_W - OFF_LSB - OFF_W - IDX_W;
  localparam int RAM_AW = LINE_W + OFF_W;
  localparam int FULL_L1_LINES = L1_BYTES / (WORDS * 4) / L1_WAYS;
  localparam int FULL_L2_LINES = L2_BYTES / (WORDS * 4) / L2_WAYS;

  typedef struct packed {
    dmc_state_e                     st;
    logic [ADDR_W-1:0]              addr;
    logic                           wr;
    logic [DATA_W-1:0]              wdata;
    logic [LINES-1:0][TAG_W-1:0]    tags;
    logic [LINES-1:0]               valid;
    logic [SETS-1:0][WAY_W-1:0]     rr;
    logic                           fill_act;
    logic [OFF_W-1:0]               fill_cnt;
    logic [ADDR_W-1:0]              fill_base;
    logic [LINE_W-1:0]              fill_slot;
    logic                           pl_valid;
    logic [1:0]                     pl_kind;
    logic [ADDR_W-1:0]              pl_addr;
  } dmc_cache_s;

  dmc_cache_s s_q;
  dmc_cache_s s_d;

  dmc_ram_if #(.AW(RAM_AW), .DW(DATA_W)) ram_bus ();

  dmc_ram #(
    .DEPTH (LINES * WORDS),
    .AW    (RAM_AW),
    .DW    (DATA_W)
  ) u_ram (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_clk_en  (i_clk_en),
    .bus       (ram_bus)
  );

  function automatic logic [OFF_W-1:0] off_of(input logic [ADDR_W-1:0] a);
    off_of = a[OFF_LSB +: OFF_W];
  endfunction : off_of
  function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = a[OFF_LSB + OFF_W +: IDX_W];
  endfunction : idx_of
  function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
    tag_of = a[ADDR_W-1 -: TAG_W];
  endfunction : tag_of
  function automatic logic [LINE_W-1:0] slot_of(input logic [IDX_W-1:0] s,
                                                 input logic [WAY_W-1:0] w);
    slot_of = LINE_W'(int'(s) * WAYS + ((WAYS > 1) ? int'(w) : 0));
  endfunction : slot_of
  // Returns hit flag above the hitting way
  function automatic logic [WAY_W:0] lookup(
    input logic [ADDR_W-1:0]           a,
    input logic [LINES-1:0][TAG_W-1:0] tg,
    input logic [LINES-1:0]            vl
  );
    logic [LINE_W-1:0] sl;
    lookup = '0;
    for (int w = 0; w < WAYS; w++)
    begin
      sl = slot_of(idx_of(a), WAY_W'(w));
      if (vl[sl] && tg[sl] == tag_of(a))
        lookup = {1'b1, WAY_W'(w)};
    end
  endfunction : lookup

  logic [WAY_W:0]    core_lk;
  logic [WAY_W:0]    pl_lk;
  logic              fill_wr;
  logic              fill_go;
  logic [ADDR_W-1:0] go_addr;
  logic [IDX_W-1:0]  go_set;
  logic [WAY_W-1:0]  go_way;
  logic [IDX_W-1:0]  fill_set;

  assign core_lk  = lookup(s_q.addr, s_q.tags, s_q.valid);
  assign pl_lk    = lookup(s_q.pl_addr, s_q.tags, s_q.valid);
  assign fill_wr  = s_q.fill_act && i_mem_rd_valid;
  assign fill_set = idx_of(s_q.fill_base);

  always_comb
  begin
    s_d           = s_q;
    fill_go       = 1'b0;
    go_addr       = s_q.addr;
    ram_bus.we    = 1'b0;
    ram_bus.waddr = '0;
    ram_bus.wdata = '0;
    ram_bus.re    = 1'b0;
    ram_bus.raddr = {slot_of(idx_of(s_q.addr), core_lk[WAY_W-1:0]),
                     off_of(s_q.addr)};

    // Core load/store sequencer
    case (s_q.st)
      ST_IDLE:
      begin
        if (i_req_valid)
        begin
          s_d.addr  = i_req_addr;
          s_d.wr    = i_req_write;
          s_d.wdata = i_req_wdata;
          s_d.st    = ST_LOOKUP;
        end
      end
      ST_LOOKUP:
      begin
        if (core_lk[WAY_W])
        begin
          if (!s_q.wr)
          begin
            ram_bus.re = 1'b1;
            s_d.st     = ST_RESP;
          end
          else if (!fill_wr)
          begin
            ram_bus.we    = 1'b1;
            ram_bus.waddr = ram_bus.raddr;
            ram_bus.wdata = s_q.wdata;
            s_d.st        = ST_MEMWR;
          end
        end
        else
          s_d.st = (s_q.wr && !i_write_allocate) ? ST_MEMWR
                                                  : ST_MISS;
      end
      ST_MISS:
      begin
        if (!s_q.fill_act)
        begin
          fill_go = 1'b1;
          s_d.st  = ST_FILLW;
        end
      end
      ST_FILLW: if (!s_q.fill_act)
        s_d.st = ST_LOOKUP;
      ST_MEMWR: if (i_mem_wr_ack)
        s_d.st = ST_RESP;
      ST_RESP: s_d.st = ST_IDLE;
      default: s_d.st = ST_IDLE;
    endcase

    // Preload slot; a data preload starts its fill only while the core sequencer is in ST_IDLE with no i_req_valid
    if (s_q.pl_valid)
    begin
      if (s_q.pl_kind == PLD_INSTRUCTION_PRELOAD_HINT)
      begin
        if (i_ipre_ready)
          s_d.pl_valid = 1'b0;
      end
      else if (pl_lk[WAY_W])
        s_d.pl_valid = 1'b0;
      else if (!s_q.fill_act && !fill_go && s_q.st == ST_IDLE
               && !i_req_valid)
      begin
        fill_go      = 1'b1;
        go_addr      = s_q.pl_addr;
        s_d.pl_valid = 1'b0;
      end
    end
    if (i_pld_valid && !s_q.pl_valid)
    begin
      s_d.pl_valid = 1'b1;
      s_d.pl_kind  = i_pld_kind;
      s_d.pl_addr  = i_pld_addr;
    end

    // Line-fill engine
    go_set = idx_of(go_addr);
    go_way = (WAYS > 1) ? s_q.rr[go_set] : '0;
    if (fill_go)
    begin
      s_d.fill_act  = 1'b1;
      s_d.fill_cnt  = '0;
      s_d.fill_base = {go_addr[ADDR_W-1:OFF_LSB + OFF_W],
                       (OFF_LSB + OFF_W)'(0)};
      s_d.fill_slot = slot_of(go_set, go_way);
      s_d.valid[slot_of(go_set, go_way)] = 1'b0;
      s_d.tags[slot_of(go_set, go_way)]  = tag_of(go_addr);
    end
    if (fill_wr)
    begin
      ram_bus.we    = 1'b1;
      ram_bus.waddr = {s_q.fill_slot, s_q.fill_cnt};
      ram_bus.wdata = i_mem_rd_data;
      s_d.fill_cnt  = s_q.fill_cnt + 1'b1;
      if (s_q.fill_cnt == OFF_W'(WORDS - 1))
      begin
        s_d.fill_act              = 1'b0;
        s_d.valid[s_q.fill_slot]  = 1'b1;
        s_d.rr[fill_set] = (int'(s_q.rr[fill_set]) == WAYS - 1) ? '0 :
                           s_q.rr[fill_set] + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s_q         <= '0;
      s_q.st      <= ST_IDLE;
      s_q.pl_kind <= RST_KIND;
    end
    else if (i_clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign o_req_ready   = (s_q.st == ST_IDLE);
  assign o_rsp_valid   = (s_q.st == ST_RESP);
  assign o_rsp_rdata   = ram_bus.rdata;
  assign o_pld_ready   = !s_q.pl_valid;
  assign o_instruction_preload_hint = s_q.pl_valid &&
    (s_q.pl_kind == PLD_INSTRUCTION_PRELOAD_HINT);
  assign o_ipre_addr   = s_q.pl_addr;
  assign o_mem_rd_req  = s_q.fill_act;
  assign o_mem_rd_addr = s_q.fill_base;
  assign o_mem_wr_req  = (s_q.st == ST_MEMWR);
  assign o_mem_wr_addr = s_q.addr;
  assign o_mem_wr_data = s_q.wdata;

endmodule : dmc_cache

// ### logic/dmc_pkg.sv
package dmc_pkg;

  // Address and data geometry of the small direct-mapped cache
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;
  localparam int CACHE_BYTES = 64;
  localparam int LINE_WORDS  = 4;
  localparam int NUM_LINES   = 4;
  localparam int NUM_WAYS    = 1;
  localparam int OFF_LSB     = 2;
  localparam int IDX_LSB     = 4;
  localparam int TAG_LSB     = 6;

  // Geometry of the full-size first and second level caches
  localparam int L1_BYTES    = 32768;
  localparam int L1_WAYS     = 4;
  localparam int L2_BYTES    = 524288;
  localparam int L2_WAYS     = 8;
  localparam int L2_CORES    = 2;

  // Preload hint kinds on i_pld_kind
  localparam logic [1:0] PLD_DATA                        = 2'h0;
  localparam logic [1:0] PLD_DATA_PRELOAD_FOR_WRITE_HINT = 2'h1;
  localparam logic [1:0] PLD_INSTRUCTION_PRELOAD_HINT    = 2'h2;

  // Values after reset
  localparam logic [1:0] RST_KIND = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOOKUP,
    ST_MISS,
    ST_FILLW,
    ST_MEMWR,
    ST_RESP
  } dmc_state_e;

endpackage : dmc_pkg

// ### logic/dmc_ram.sv
`timescale 1ns/1ps
module dmc_ram #(
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter int DW    = 32
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  input  wire logic i_clk_en,
  // Array port
  dmc_ram_if.ram    bus
);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0]            rdata;
  } dmc_ram_s;

  dmc_ram_s s_q;
  dmc_ram_s s_d;

  always_comb
  begin
    s_d = s_q;
    if (bus.we)
    begin
      s_d.mem[bus.waddr] = bus.wdata;
    end
    if (bus.re)
    begin
      s_d.rdata = s_q.mem[bus.raddr];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s_q <= '0;
    end
    else if (i_clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign bus.rdata = s_q.rdata;

endmodule : dmc_ram

// ### logic/dmc_ram_if.sv
`timescale 1ns/1ps
interface dmc_ram_if #(
  parameter int AW = 4,
  parameter int DW = 32
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic          re;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output re,
                output raddr, input rdata);
  modport ram  (input we, input waddr, input wdata, input re,
                input raddr, output rdata);
endinterface : dmc_ram_if

// ### tb/dmc_cache_sva.sv
`timescale 1ns/1ps
module dmc_cache_sva (
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_reset_n,
  input wire logic        i_clk_en,
  // Core and hint ports
  input wire logic        i_req_valid,
  input wire logic        o_req_ready,
  input wire logic        o_rsp_valid,
  input wire logic        o_instruction_preload_hint,
  input wire logic [31:0] o_ipre_addr,
  input wire logic        i_ipre_ready,
  // Memory ports
  input wire logic        o_mem_rd_req,
  input wire logic [31:0] o_mem_rd_addr,
  input wire logic        i_mem_rd_valid,
  input wire logic        o_mem_wr_req,
  input wire logic [31:0] o_mem_wr_addr,
  input wire logic        i_mem_wr_ack
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic [2:0] beat_q;
  // Beats seen in the running fill
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
    if (!i_reset_n)
      beat_q <= 3'h0;
    else if (!o_mem_rd_req)
      beat_q <= 3'h0;
    else if (i_mem_rd_valid && i_clk_en)
      beat_q <= beat_q + 3'h1;
  fill_align_a: assert property (
    o_mem_rd_req |-> o_mem_rd_addr[3:0] == 4'h0) else $error("fill base");
  fill_len_a: assert property (
    o_mem_rd_req && i_mem_rd_valid && beat_q == 3'h3 |=> !o_mem_rd_req)
    else $error("fill length");
  fill_hold_a: assert property (
    o_mem_rd_req && $past(o_mem_rd_req) |-> $stable(o_mem_rd_addr))
    else $error("fill address moved");
  wr_hold_a: assert property (
    o_mem_wr_req && !i_mem_wr_ack |=> o_mem_wr_req && $stable(o_mem_wr_addr))
    else $error("write dropped");
  wr_answer_a: assert property (
    o_mem_wr_req && i_mem_wr_ack |=> o_rsp_valid) else $error("store answer");
  hint_hold_a: assert property (
    o_instruction_preload_hint && !i_ipre_ready |=>
    o_instruction_preload_hint && $stable(o_ipre_addr)) else $error("hint");
  req_busy_a: assert property (
    i_clk_en && i_req_valid && o_req_ready |=> !o_req_ready [*2])
    else $error("busy");
  rsp_idle_a: assert property (
    o_rsp_valid |=> o_req_ready && !o_rsp_valid) else $error("answer pulse");
endmodule : dmc_cache_sva
bind dmc_cache dmc_cache_sva dmc_cache_sva_i (.i_clk_sys, .i_reset_n,
  .i_clk_en,
  .i_req_valid, .o_req_ready, .o_rsp_valid, .o_instruction_preload_hint,
  .o_ipre_addr, .i_ipre_ready, .o_mem_rd_req, .o_mem_rd_addr,
  .i_mem_rd_valid, .o_mem_wr_req, .o_mem_wr_addr, .i_mem_wr_ack);

// ### tb/dmc_cache_tb_top.sv
`timescale 1ns/1ps
module dmc_cache_tb_top;
  import dmc_pkg::*;
  logic i_clk_sys = 0, i_reset_n = 0, i_clk_en = 1, i_write_allocate = 0;
  logic i_req_valid = 0, i_req_write = 0, i_pld_valid = 0;
  logic [31:0] i_req_addr = 0, i_req_wdata = 0, i_pld_addr = 0;
  logic [1:0] i_pld_kind = 0;
  logic o_req_ready, o_rsp_valid, o_pld_ready, o_instruction_preload_hint;
  logic i_ipre_ready, o_mem_rd_req, i_mem_rd_valid, o_mem_wr_req;
  logic i_mem_wr_ack, rq_q = 0;
  logic [31:0] o_rsp_rdata, o_ipre_addr, o_mem_rd_addr, i_mem_rd_data;
  logic [31:0] o_mem_wr_addr, o_mem_wr_data, fa, sh [logic [31:0]];
  logic [25:0] tg [4];
  logic [3:0] vl = 0;
  int seed = 61656, err_total = 0, comparisons = 0, fills = 0, r;
  always #25 i_clk_sys = ~i_clk_sys;
  dmc_cache dmc_cache_i (.i_clk_sys, .i_reset_n, .i_clk_en,
    .i_write_allocate, .i_req_valid, .i_req_write, .i_req_addr,
    .i_req_wdata, .o_req_ready, .o_rsp_valid, .o_rsp_rdata, .i_pld_valid,
    .i_pld_kind, .i_pld_addr, .o_pld_ready, .o_instruction_preload_hint,
    .o_ipre_addr, .i_ipre_ready, .o_mem_rd_req, .o_mem_rd_addr,
    .i_mem_rd_valid, .i_mem_rd_data, .o_mem_wr_req, .o_mem_wr_addr,
    .o_mem_wr_data, .i_mem_wr_ack);
  dmc_mem_model dmc_mem_model_i (.i_clk_sys, .i_rd_req(o_mem_rd_req),
    .i_rd_addr(o_mem_rd_addr), .o_rd_valid(i_mem_rd_valid),
    .o_rd_data(i_mem_rd_data), .i_wr_req(o_mem_wr_req),
    .i_wr_addr(o_mem_wr_addr), .i_wr_data(o_mem_wr_data),
    .o_wr_ack(i_mem_wr_ack), .i_hint(o_instruction_preload_hint),
    .o_hint_ready(i_ipre_ready));
  // Counts line fills and keeps their base
  always @(posedge i_clk_sys)
  begin
    rq_q <= o_mem_rd_req;
    if (o_mem_rd_req && !rq_q)
    begin
      fills++;
      fa = o_mem_rd_addr;
    end
  end
  task automatic stop_test;
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  function automatic logic res(input logic [31:0] a);
    return vl[a[5:4]] === 1'b1 && tg[a[5:4]] === a[31:6];
  endfunction : res
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    int f0;
    logic hit;
    logic [31:0] e;
    hit = res(a);
    f0 = fills;
    e = sh.exists(a) ? sh[a] : {a[15:0], ~a[15:0]};
    @(negedge i_clk_sys);
    {i_req_valid, i_req_write, i_req_addr, i_req_wdata} = {1'b1, w, a, d};
    for (n = 0; o_req_ready !== 1'b1 && n < 60; n++)
      @(negedge i_clk_sys);
    if (n >= 60)
    begin
      chk(0, "never ready");
      stop_test;
    end
    @(negedge i_clk_sys);
    i_req_valid = 0;
    for (n = 1; o_rsp_valid !== 1'b1 && n < 90; n++)
      @(negedge i_clk_sys);
    if (n >= 90)
    begin
      chk(0, "no answer");
      stop_test;
    end
    if (!w)
      chk(o_rsp_rdata === e && (!hit || n == 2), "load");
    chk(fills - f0 == int'(!hit && (!w || i_write_allocate)), "fill");
    if (fills != f0)
      chk(fa === {a[31:4], 4'h0}, "fill base");
    if (!w || i_write_allocate)
      {vl[a[5:4]], tg[a[5:4]]} = {1'b1, a[31:6]};
    if (w)
      chk(dmc_mem_model_i.mem[a] === d, "store");
    if (w)
      sh[a] = d;
  endtask : acc
  task automatic pld(input logic [1:0] k, input logic [31:0] a);
    int n;
    int f0;
    logic ok;
    logic seen;
    {f0, ok, seen} = {fills, 1'b1, 1'b0};
    @(negedge i_clk_sys);
    chk(o_pld_ready, "slot busy");
    {i_pld_valid, i_pld_kind, i_pld_addr} = {1'b1, k, a};
    @(negedge i_clk_sys);
    i_pld_valid = 0;
    for (n = 0; n < 90 && (o_pld_ready !== 1'b1 || o_mem_rd_req !== 1'b0
         || o_instruction_preload_hint !== 1'b0); n++)
    begin
      ok &= o_req_ready;
      seen |= o_instruction_preload_hint && o_ipre_addr === a;
      @(negedge i_clk_sys);
    end
    chk(n < 90 && ok, "core stalled");
    if (n >= 90)
      stop_test;
    if (k == PLD_INSTRUCTION_PRELOAD_HINT)
      chk(seen && fills == f0, "hint");
    else
      chk(fills - f0 == int'(!res(a)), "preload fill");
    if (k != PLD_INSTRUCTION_PRELOAD_HINT)
      {vl[a[5:4]], tg[a[5:4]]} = {1'b1, a[31:6]};
  endtask : pld
  initial
  begin
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_reset_n = 1;
    chk(o_req_ready && o_pld_ready && !o_mem_rd_req, "reset");
    chk(CACHE_BYTES == NUM_LINES * LINE_WORDS * 4, "size");
    chk(L1_BYTES == 32768 && L1_WAYS == 4, "l1");
    chk(L2_BYTES == 524288 && L2_WAYS == 8, "l2");
    acc(0, 32'h40, 0);
    acc(0, 32'h4c, 0);
    acc(0, 32'h80, 0);
    acc(0, 32'h44, 0);
    acc(1, 32'h0, 32'h1234abcd);
    i_write_allocate = 1;
    acc(1, 32'h104, 32'h5a5a0f0f);
    acc(0, 32'h104, 0);
    for (int k = 0; k < 4; k++)
      pld(2'(k), 32'h200 + 32'(k * 16));
    for (int k = 0; k < 4; k++)
      acc(0, 32'h200 + 32'(k * 16), 0);
    // Reset in mid-run forgets every line
    @(negedge i_clk_sys);
    i_reset_n = 0;
    @(negedge i_clk_sys);
    i_reset_n = 1;
    vl = 0;
    chk(o_req_ready && o_pld_ready && !o_mem_rd_req, "reset");
    acc(0, 32'h210, 0);
    // Clock enable low freezes a pending request
    @(negedge i_clk_sys);
    i_clk_en = 0;
    {i_req_valid, i_req_addr} = {1'b1, 32'h210};
    repeat (3) @(negedge i_clk_sys);
    chk(o_req_ready && !o_rsp_valid && !o_mem_rd_req, "freeze");
    {i_req_valid, i_clk_en} = 2'h1;
    acc(0, 32'h210, 0);
    repeat (300)
    begin
      r = $random(seed);
      i_write_allocate = r[8];
      if (r[1:0] == 2'h0)
        pld(r[3:2], 32'($random(seed)) & 32'h800001fc);
      else
        acc(r[4], 32'($random(seed)) & 32'h800001fc, $random(seed));
    end
    stop_test;
  end
endmodule : dmc_cache_tb_top

// ### tb/dmc_mem_model.sv
`timescale 1ns/1ps
module dmc_mem_model (
  // Clock
  input  wire logic        i_clk_sys,
  // Line read
  input  wire logic        i_rd_req,
  input  wire logic [31:0] i_rd_addr,
  output logic             o_rd_valid,
  output logic [31:0]      o_rd_data,
  // Word write
  input  wire logic        i_wr_req,
  input  wire logic [31:0] i_wr_addr,
  input  wire logic [31:0] i_wr_data,
  output logic             o_wr_ack,
  // Instruction hint
  input  wire logic        i_hint,
  output logic             o_hint_ready
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] a;
  int          beat = 0;
  int          seed = 61656;
  initial
  begin
    o_rd_valid = 1'b0;
    o_rd_data = 32'h0;
    o_wr_ack = 1'b0;
    o_hint_ready = 1'b0;
  end
  // Random stalls; idle data line toggles
  always @(negedge i_clk_sys)
  begin
    a = {i_rd_addr[31:4], 4'h0} + 32'(beat * 4);
    if (i_rd_req && beat < 4 && ($random(seed) & 1))
    begin
      o_rd_valid = 1'b1;
      o_rd_data = mem.exists(a) ? mem[a] : {a[15:0], ~a[15:0]};
      beat++;
    end
    else
    begin
      o_rd_valid = 1'b0;
      o_rd_data = ~o_rd_data;
    end
    if (!i_rd_req)
      beat = 0;
    o_wr_ack = i_wr_req && !o_wr_ack && ($random(seed) & 1);
    if (o_wr_ack)
      mem[i_wr_addr] = i_wr_data;
    o_hint_ready = i_hint && !o_hint_ready && ($random(seed) & 1);
  end
endmodule : dmc_mem_model
